// ---- inc/trwc_pkg.sv ----
// Purpose: shared constants and types of the transceiver rate and wrap control
// Assumes: core clock of 50 MHz
// Notes:   serial register offsets and field positions live here only
package trwc_pkg;

  // clock and recovery-stage lock timing
  localparam int unsigned CORE_CLK_PERIOD_NS = 20;
  localparam int unsigned LOCK_TIME_US       = 500;
  // longest time, so rounded down to whole cycles
  localparam int unsigned LOCK_CYCLES        = (LOCK_TIME_US * 1000) / CORE_CLK_PERIOD_NS;

  // two-wire serial framing
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [2:0] LAST_BIT_IDX  = 3'h7;
  localparam logic [6:0] DEV_ADDR_DEF  = 7'h50;

  // register offsets
  localparam logic [7:0] REG_WRAP    = 8'h00;
  localparam logic [7:0] REG_TX_EQ   = 8'h01;
  localparam logic [7:0] REG_RX_EMPH = 8'h02;
  localparam logic [7:0] REG_STATUS  = 8'h03;

  // wrap control fields
  localparam int unsigned WRAP_OPT_BIT  = 0;
  localparam int unsigned WRAP_ELEC_BIT = 1;
  localparam int unsigned WRAP_PASS_BIT = 2;
  localparam int unsigned WRAP_W        = 3;

  // status fields
  localparam int unsigned ST_RX_LOCK_BIT = 0;
  localparam int unsigned ST_TX_LOCK_BIT = 1;
  localparam int unsigned ST_LOS_BIT     = 2;
  localparam int unsigned ST_FAULT_BIT   = 3;
  localparam int unsigned ST_RX_RATE_BIT = 4;
  localparam int unsigned ST_TX_RATE_BIT = 5;

  // reset values: normal, non-wrapped operation
  localparam logic [2:0] WRAP_RST = 3'h0;
  localparam logic [7:0] EQ_RST   = 8'h00;
  localparam logic [7:0] EMPH_RST = 8'h00;

  typedef enum logic [3:0] {
    TRWC_IDLE,
    TRWC_ADDR,
    TRWC_ADDR_ACK,
    TRWC_PTR,
    TRWC_PTR_ACK,
    TRWC_WDATA,
    TRWC_WDATA_ACK,
    TRWC_RDATA,
    TRWC_RDATA_ACK
  } trwc_ser_state_type;

endpackage : trwc_pkg

// ---- hw/trwc_control.sv ----
// Purpose: low-speed control of a pluggable optical transceiver: rate select,
//          recovery-stage lock, wrap modes, eq/emphasis, fault and presence pins
// Assumes: all pin inputs synchronous to core_clk; pad pulls resolve open pins
// Notes:   two-wire slave holds wrap, eq, emphasis and a read-only status byte

module trwc_control import trwc_pkg::*; #(
  parameter int unsigned ACQ_CYCLES = LOCK_CYCLES,
  parameter int unsigned EQ_W       = 3,
  parameter int unsigned EMPH_W     = 3,
  parameter logic [6:0]  DEV_ADDR   = DEV_ADDR_DEF
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  // rate selects and transmit disable
  input  wire logic              rx_rate_select,
  input  wire logic              tx_rate_select,
  input  wire logic              tx_disable,
  // analog front-end sense
  input  wire logic              rx_coding_16g,
  input  wire logic              tx_coding_16g,
  input  wire logic              laser_fault,
  input  wire logic              rx_power_low,
  // recovery stage and path control
  output logic                   rx_cdr_engaged,
  output logic                   tx_cdr_engaged,
  output logic                   rx_cdr_locked,
  output logic                   tx_cdr_locked,
  output logic                   laser_enable,
  output logic                   laser_src_wrap,
  output logic                   rd_output_enable,
  output logic                   rd_src_wrap,
  output logic [EQ_W-1:0]        tx_eq_setting,
  output logic [EMPH_W-1:0]      rx_emph_setting,
  // open-drain status pins
  output logic                   tx_fault_out,
  output logic                   tx_fault_oe,
  output logic                   optical_signal_lost_out,
  output logic                   optical_signal_lost_oe,
  output logic                   presence_pin_out,
  output logic                   presence_pin_oe,
  // two-wire serial pins
  input  wire logic              serial_clock_pin_in,
  input  wire logic              serial_data_pin_in,
  output logic                   serial_data_pin_out,
  output logic                   serial_data_pin_oe
);

  localparam int unsigned CW = $clog2(ACQ_CYCLES + 1);
  default clocking core_cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  initial begin
    if (ACQ_CYCLES < 1 || ACQ_CYCLES > LOCK_CYCLES) begin
      $error("ACQ_CYCLES must lie between 1 and the lock time");
    end
    if (EQ_W < 1 || EQ_W > 8 || EMPH_W < 1 || EMPH_W > 8) begin
      $error("EQ_W and EMPH_W must lie between 1 and 8");
    end
  end

  // shared lock counter step: counts only unbroken 16GFC coding
  function automatic logic [CW-1:0] lock_next(input logic engaged,
                                              input logic coding_16g,
                                              input logic [CW-1:0] cnt);
    if (!engaged || !coding_16g) begin
      lock_next = '0;
    end else if (cnt == CW'(ACQ_CYCLES)) begin
      lock_next = cnt;
    end else begin
      lock_next = cnt + CW'(1);
    end
  endfunction : lock_next

  logic [WRAP_W-1:0]  wrap_q;
  logic [EQ_W-1:0]    eq_q;
  logic [EMPH_W-1:0]  emph_q;
  logic [CW-1:0]      rx_cnt_q;
  logic [CW-1:0]      tx_cnt_q;
  logic [CW-1:0]      rx_cnt_d;
  logic [CW-1:0]      tx_cnt_d;
  logic               opt_wrap;
  logic               elec_wrap;
  logic               pass_thru;

  assign opt_wrap  = wrap_q[WRAP_OPT_BIT];
  assign elec_wrap = wrap_q[WRAP_ELEC_BIT];
  assign pass_thru = wrap_q[WRAP_PASS_BIT];

  // recovery stage in path for high rate or for the wrap through it
  assign rx_cdr_engaged = rx_rate_select | opt_wrap;
  assign tx_cdr_engaged = tx_rate_select | elec_wrap;
  assign rx_cnt_d = lock_next(rx_cdr_engaged, rx_coding_16g, rx_cnt_q);
  assign tx_cnt_d = lock_next(tx_cdr_engaged, tx_coding_16g, tx_cnt_q);

  // unsaturated run lengths, only for the lock bound checks
  logic [31:0] rx_run_q;
  logic [31:0] tx_run_q;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_cnt_q      <= '0;
      tx_cnt_q      <= '0;
      rx_cdr_locked <= 1'b0;
      tx_cdr_locked <= 1'b0;
      rx_run_q      <= '0;
      tx_run_q      <= '0;
    end else begin
      rx_cnt_q      <= rx_cnt_d;
      tx_cnt_q      <= tx_cnt_d;
      rx_cdr_locked <= (rx_cnt_d == CW'(ACQ_CYCLES));
      tx_cdr_locked <= (tx_cnt_d == CW'(ACQ_CYCLES));
      rx_run_q <= (rx_cdr_engaged && rx_coding_16g) ? rx_run_q + 32'h0000_0001 : '0;
      tx_run_q <= (tx_cdr_engaged && tx_coding_16g) ? tx_run_q + 32'h0000_0001 : '0;
    end
  end

  // output path selection
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      laser_enable     <= 1'b0;
      laser_src_wrap   <= 1'b0;
      rd_output_enable <= 1'b0;
      rd_src_wrap      <= 1'b0;
      tx_eq_setting    <= '0;
      rx_emph_setting  <= '0;
    end else begin
      laser_enable     <= !tx_disable && !(elec_wrap && !pass_thru);
      laser_src_wrap   <= opt_wrap;
      rd_output_enable <= !(opt_wrap && !pass_thru);
      rd_src_wrap      <= elec_wrap;
      tx_eq_setting    <= eq_q;
      rx_emph_setting  <= emph_q;
    end
  end

  // open-drain pins: enable high pulls the wire low
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_fault_oe            <= 1'b1;
      optical_signal_lost_oe <= 1'b1;
    end else begin
      tx_fault_oe            <= !laser_fault;
      optical_signal_lost_oe <= !rx_power_low;
    end
  end

  assign tx_fault_out            = 1'b0;
  assign optical_signal_lost_out = 1'b0;
  assign presence_pin_out        = 1'b0;
  assign presence_pin_oe         = 1'b1;
  assign serial_data_pin_out     = 1'b0;

  // two-wire serial slave
  trwc_ser_state_type state_q;
  logic               scl_q;
  logic               sda_q;
  logic [3:0]         bit_cnt_q;
  logic [7:0]         shift_q;
  logic [7:0]         ptr_q;
  logic               scl_rise;
  logic               scl_fall;
  logic               start_cond;
  logic               stop_cond;
  logic               wr_stb;
  logic               byte_done;

  assign scl_rise   = serial_clock_pin_in && !scl_q;
  assign scl_fall   = !serial_clock_pin_in && scl_q;
  assign start_cond = serial_clock_pin_in && scl_q && sda_q && !serial_data_pin_in;
  assign stop_cond  = serial_clock_pin_in && scl_q && !sda_q && serial_data_pin_in;
  assign byte_done  = scl_fall && (bit_cnt_q == BITS_PER_BYTE);
  assign wr_stb     = (state_q == TRWC_WDATA) && byte_done;

  function automatic logic [7:0] read_reg(input logic [7:0] addr);
    read_reg = 8'h00;
    unique case (addr)
      REG_WRAP:    read_reg = 8'(wrap_q);
      REG_TX_EQ:   read_reg = 8'(eq_q);
      REG_RX_EMPH: read_reg = 8'(emph_q);
      REG_STATUS: begin
        read_reg[ST_RX_LOCK_BIT] = rx_cdr_locked;
        read_reg[ST_TX_LOCK_BIT] = tx_cdr_locked;
        read_reg[ST_LOS_BIT]     = rx_power_low;
        read_reg[ST_FAULT_BIT]   = laser_fault;
        read_reg[ST_RX_RATE_BIT] = rx_rate_select;
        read_reg[ST_TX_RATE_BIT] = tx_rate_select;
      end
      default: read_reg = 8'h00;
    endcase
  endfunction : read_reg

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= serial_clock_pin_in;
      sda_q <= serial_data_pin_in;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q   <= TRWC_IDLE;
      bit_cnt_q <= '0;
      shift_q   <= '0;
      ptr_q     <= '0;
    end else if (start_cond) begin
      state_q   <= TRWC_ADDR;
      bit_cnt_q <= '0;
    end else if (stop_cond) begin
      state_q <= TRWC_IDLE;
    end else begin
      unique case (state_q)
        TRWC_IDLE: begin
          bit_cnt_q <= '0;
        end
        TRWC_ADDR, TRWC_PTR, TRWC_WDATA: begin
          if (scl_rise) begin
            shift_q   <= {shift_q[6:0], serial_data_pin_in};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (byte_done) begin
            bit_cnt_q <= '0;
            if (state_q == TRWC_ADDR) begin
              state_q <= (shift_q[7:1] == DEV_ADDR) ? TRWC_ADDR_ACK : TRWC_IDLE;
            end else if (state_q == TRWC_PTR) begin
              ptr_q   <= shift_q;
              state_q <= TRWC_PTR_ACK;
            end else begin
              ptr_q   <= ptr_q + 8'h01;
              state_q <= TRWC_WDATA_ACK;
            end
          end
        end
        TRWC_ADDR_ACK, TRWC_PTR_ACK, TRWC_WDATA_ACK: begin
          if (scl_fall) begin
            if (state_q == TRWC_ADDR_ACK && shift_q[0]) begin
              shift_q <= read_reg(ptr_q);
              ptr_q   <= ptr_q + 8'h01;
              state_q <= TRWC_RDATA;
            end else begin
              state_q <= (state_q == TRWC_ADDR_ACK) ? TRWC_PTR : TRWC_WDATA;
            end
          end
        end
        TRWC_RDATA: begin
          if (scl_fall) begin
            if (bit_cnt_q[2:0] == LAST_BIT_IDX) begin
              bit_cnt_q <= '0;
              state_q   <= TRWC_RDATA_ACK;
            end else begin
              shift_q   <= {shift_q[6:0], 1'b0};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
          end
        end
        TRWC_RDATA_ACK: begin
          if (scl_rise) begin
            shift_q[0] <= serial_data_pin_in;
          end else if (scl_fall) begin
            if (!shift_q[0]) begin
              shift_q <= read_reg(ptr_q);
              ptr_q   <= ptr_q + 8'h01;
              state_q <= TRWC_RDATA;
            end else begin
              state_q <= TRWC_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_comb begin
    unique case (state_q)
      TRWC_ADDR_ACK, TRWC_PTR_ACK, TRWC_WDATA_ACK: serial_data_pin_oe = 1'b1;
      TRWC_RDATA: serial_data_pin_oe = !shift_q[7];
      default:    serial_data_pin_oe = 1'b0;
    endcase
  end

  // control registers, normal operation after reset
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wrap_q <= WRAP_RST;
      eq_q   <= EQ_W'(EQ_RST);
      emph_q <= EMPH_W'(EMPH_RST);
    end else if (wr_stb) begin
      unique case (ptr_q)
        REG_WRAP:    wrap_q <= shift_q[WRAP_W-1:0];
        REG_TX_EQ:   eq_q   <= shift_q[EQ_W-1:0];
        REG_RX_EMPH: emph_q <= shift_q[EMPH_W-1:0];
        default:     wrap_q <= wrap_q;
      endcase
    end
  end

  property p_rx_bypass;
    (!rx_rate_select && !opt_wrap) |-> !rx_cdr_engaged;
  endproperty
  a_rx_bypass: assert property (p_rx_bypass) else $error("rx recovery not bypassed");
  property p_tx_bypass;
    (!tx_rate_select && !elec_wrap) |-> !tx_cdr_engaged;
  endproperty
  a_tx_bypass: assert property (p_tx_bypass) else $error("tx recovery not bypassed");
  property p_rx_lock_bound;
    (rx_run_q >= 32'(ACQ_CYCLES)) |-> rx_cdr_locked;
  endproperty
  a_rx_lock_bound: assert property (p_rx_lock_bound) else $error("rx lock late");
  property p_tx_lock_bound;
    (tx_run_q >= 32'(ACQ_CYCLES)) |-> tx_cdr_locked;
  endproperty
  a_tx_lock_bound: assert property (p_tx_lock_bound) else $error("tx lock late");
  property p_no_false_lock;
    (!rx_coding_16g || !rx_cdr_engaged) |=> !rx_cdr_locked;
  endproperty
  a_no_false_lock: assert property (p_no_false_lock) else $error("lock without 16g coding");
  property p_laser_off;
    tx_disable |=> !laser_enable;
  endproperty
  a_laser_off: assert property (p_laser_off) else $error("laser on while disabled");
  property p_fault_pin;
    1'b1 |=> (tx_fault_oe == !$past(laser_fault));
  endproperty
  a_fault_pin: assert property (p_fault_pin) else $error("fault pin wrong");
  property p_los_pin;
    rx_power_low ##1 rx_power_low |-> !optical_signal_lost_oe;
  endproperty
  a_los_pin: assert property (p_los_pin) else $error("loss pin driven low");
  property p_presence;
    presence_pin_oe && !presence_pin_out;
  endproperty
  a_presence: assert property (p_presence) else $error("presence not grounded");
  property p_addr_ack;
    (state_q == TRWC_ADDR && byte_done && shift_q[7:1] == DEV_ADDR && !start_cond
     && !stop_cond) |=> serial_data_pin_oe;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address not acknowledged");
  property p_eq_write;
    (wr_stb && ptr_q == REG_TX_EQ && !start_cond && !stop_cond) |=> ##1
      (tx_eq_setting == $past(shift_q[EQ_W-1:0], 2));
  endproperty
  a_eq_write: assert property (p_eq_write) else $error("eq write lost");
  property p_wrap_cdr;
    (opt_wrap |-> rx_cdr_engaged) and (elec_wrap |-> tx_cdr_engaged);
  endproperty
  a_wrap_cdr: assert property (p_wrap_cdr) else $error("wrap without recovery");

endmodule : trwc_control

// ---- dv/trwc_host_model.sv ----
// Purpose: host board side: pull-ups on open-drain pins and a two-wire master
// Assumes: four core clocks per half bit on the serial clock
// Notes:   tasks are called by the testbench just after a rising edge
module trwc_host_model import trwc_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF
) (
  // clock
  input  wire logic core_clk,
  // open-drain drives from the module
  input  wire logic fault_out,
  input  wire logic fault_oe,
  input  wire logic los_out,
  input  wire logic los_oe,
  input  wire logic pres_out,
  input  wire logic pres_oe,
  input  wire logic sda_out,
  input  wire logic sda_oe,
  // resolved wire levels
  output logic      fault_pin,
  output logic      los_pin,
  output logic      pres_pin,
  output logic      scl_pin,
  output logic      sda_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  logic scl_low_q = 1'b0;
  logic sda_low_q = 1'b0;

  // pull-ups on every open-drain line
  assign fault_pin = fault_oe ? fault_out : 1'b1;
  assign los_pin   = los_oe ? los_out : 1'b1;
  assign pres_pin  = pres_oe ? pres_out : 1'b1;
  assign scl_pin   = !scl_low_q;
  assign sda_pin   = !(sda_low_q || (sda_oe && !sda_out));

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick

  // data changes only while the serial clock is low
  task automatic put_bit(input logic b);
    sda_low_q <= !b;
    tick(2);
    scl_low_q <= 1'b0;
    tick(4);
    scl_low_q <= 1'b1;
    tick(2);
  endtask : put_bit

  task automatic get_bit(output logic b);
    sda_low_q <= 1'b0;
    tick(2);
    scl_low_q <= 1'b0;
    tick(2);
    b = sda_pin;
    tick(2);
    scl_low_q <= 1'b1;
    tick(2);
  endtask : get_bit

  task automatic start_cond();
    sda_low_q <= 1'b0;
    tick(2);
    scl_low_q <= 1'b0;
    tick(4);
    sda_low_q <= 1'b1;
    tick(4);
    scl_low_q <= 1'b1;
    tick(2);
  endtask : start_cond

  task automatic stop_cond();
    sda_low_q <= 1'b1;
    tick(2);
    scl_low_q <= 1'b0;
    tick(4);
    sda_low_q <= 1'b0;
    tick(4);
  endtask : stop_cond

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      put_bit(b[i]);
    end
    get_bit(a);
    ack = !a;
  endtask : send_byte

  task automatic recv_byte(input logic last, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      get_bit(b[i]);
    end
    put_bit(last);
  endtask : recv_byte

  task automatic probe(input logic [6:0] addr, output logic ack);
    start_cond();
    send_byte({addr, 1'b0}, ack);
    stop_cond();
  endtask : probe

  task automatic write_pair(input logic [7:0] ptr, input logic [15:0] d, output logic ok);
    logic [3:0] a;
    start_cond();
    send_byte({DEV_ADDR, 1'b0}, a[0]);
    send_byte(ptr, a[1]);
    send_byte(d[15:8], a[2]);
    send_byte(d[7:0], a[3]);
    stop_cond();
    ok = &a;
  endtask : write_pair

  task automatic read_pair(input logic [7:0] ptr, output logic [15:0] d, output logic ok);
    logic [2:0] a;
    start_cond();
    send_byte({DEV_ADDR, 1'b0}, a[0]);
    send_byte(ptr, a[1]);
    start_cond();
    send_byte({DEV_ADDR, 1'b1}, a[2]);
    recv_byte(1'b0, d[15:8]);
    recv_byte(1'b1, d[7:0]);
    stop_cond();
    ok = &a;
  endtask : read_pair
endmodule : trwc_host_model

// ---- dv/trwc_tb.sv ----
// Purpose: self-checking bench for the transceiver rate and wrap control
// Assumes: lock count shortened to sixteen cycles
// Notes:   one task per scenario; serial traffic goes through the host model
module testbench import trwc_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;

  localparam int ACQ = 16;
  localparam logic [7:0] WRAP_SET [4] = '{8'h01, 8'h05, 8'h02, 8'h06};

  logic core_clk, rst_b, rx_rate_select, tx_rate_select, tx_disable;
  logic rx_coding_16g, tx_coding_16g, laser_fault, rx_power_low;
  logic rx_cdr_engaged, tx_cdr_engaged, rx_cdr_locked, tx_cdr_locked;
  logic laser_enable, laser_src_wrap, rd_output_enable, rd_src_wrap;
  logic [2:0] tx_eq_setting, rx_emph_setting;
  logic fault_out, fault_oe, los_out, los_oe, pres_out, pres_oe, sda_out, sda_oe;
  logic fault_pin, los_pin, pres_pin, scl_pin, sda_pin;
  int   n_errors = 0;
  int   samples_checked = 0;

  trwc_control #(.ACQ_CYCLES(ACQ)) uut (
    .core_clk(core_clk), .rst_b(rst_b), .rx_rate_select(rx_rate_select),
    .tx_rate_select(tx_rate_select), .tx_disable(tx_disable), .rx_coding_16g(rx_coding_16g),
    .tx_coding_16g(tx_coding_16g), .laser_fault(laser_fault), .rx_power_low(rx_power_low),
    .rx_cdr_engaged(rx_cdr_engaged), .tx_cdr_engaged(tx_cdr_engaged),
    .rx_cdr_locked(rx_cdr_locked), .tx_cdr_locked(tx_cdr_locked),
    .laser_enable(laser_enable), .laser_src_wrap(laser_src_wrap),
    .rd_output_enable(rd_output_enable), .rd_src_wrap(rd_src_wrap),
    .tx_eq_setting(tx_eq_setting), .rx_emph_setting(rx_emph_setting),
    .tx_fault_out(fault_out), .tx_fault_oe(fault_oe), .optical_signal_lost_out(los_out),
    .optical_signal_lost_oe(los_oe), .presence_pin_out(pres_out), .presence_pin_oe(pres_oe),
    .serial_clock_pin_in(scl_pin), .serial_data_pin_in(sda_pin),
    .serial_data_pin_out(sda_out), .serial_data_pin_oe(sda_oe));

  trwc_host_model host (
    .core_clk(core_clk), .fault_out(fault_out), .fault_oe(fault_oe), .los_out(los_out),
    .los_oe(los_oe), .pres_out(pres_out), .pres_oe(pres_oe), .sda_out(sda_out),
    .sda_oe(sda_oe), .fault_pin(fault_pin), .los_pin(los_pin), .pres_pin(pres_pin),
    .scl_pin(scl_pin), .sda_pin(sda_pin));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = !core_clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic settle(input int n);
    repeat (n) @(negedge core_clk);
  endtask : settle

  function automatic logic lk(input logic s);
    return s ? tx_cdr_locked : rx_cdr_locked;
  endfunction : lk

  function automatic logic eng(input logic s);
    return s ? tx_cdr_engaged : rx_cdr_engaged;
  endfunction : eng

  task automatic drv(input logic s, input logic rate, input logic coding);
    @(posedge core_clk);
    if (s) begin
      tx_rate_select <= rate;
      tx_coding_16g  <= coding;
    end else begin
      rx_rate_select <= rate;
      rx_coding_16g  <= coding;
    end
  endtask : drv

  task automatic t_reset();
    logic [15:0] d;
    logic        ok;
    settle(1);
    chk(tx_eq_setting, 3'h0);
    chk(rx_emph_setting, 3'h0);
    chk({laser_src_wrap, rd_src_wrap}, 2'h0);
    chk(pres_pin, 1'b0);
    @(posedge core_clk);
    host.read_pair(REG_WRAP, d, ok);
    chk(ok, 1'b1);
    chk(d, 16'h0000);
  endtask : t_reset

  task automatic t_lock(input logic s);
    int n;
    n = 0;
    drv(s, 1'b1, 1'b0);
    settle(ACQ + 8);
    chk(eng(s), 1'b1);
    chk(lk(s), 1'b0);
    drv(s, 1'b1, 1'b1);
    while (lk(s) !== 1'b1 && n < ACQ + 8) begin
      @(negedge core_clk);
      n++;
    end
    chk(lk(s), 1'b1);
    chk(n >= ACQ - 1 && n <= ACQ + 2, 1'b1);
    drv(s, 1'b1, 1'b0);
    settle(2);
    chk(lk(s), 1'b0);
    drv(s, 1'b0, 1'b1);
    settle(ACQ + 8);
    chk({eng(s), lk(s)}, 2'h0);
  endtask : t_lock

  task automatic t_pins();
    logic [15:0] d;
    logic        ok;
    logic [7:0]  st;
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      tx_disable   <= i[0];
      laser_fault  <= i[0];
      rx_power_low <= i[1];
      settle(2);
      chk(laser_enable, !i[0]);
      chk(fault_pin, i[0]);
      chk(los_pin, i[1]);
    end
    @(posedge core_clk);
    tx_disable <= 1'b0;
    settle(2);
    chk(laser_enable, 1'b1);
    st               = 8'h00;
    st[ST_LOS_BIT]   = 1'b1;
    st[ST_FAULT_BIT] = 1'b1;
    @(posedge core_clk);
    host.read_pair(REG_STATUS, d, ok);
    chk(ok, 1'b1);
    chk(d, {st, 8'h00});
  endtask : t_pins

  task automatic t_eq_emph();
    logic [15:0] d;
    logic        ok;
    @(posedge core_clk);
    host.write_pair(REG_TX_EQ, 16'h0503, ok);
    chk(ok, 1'b1);
    settle(2);
    chk({tx_eq_setting, rx_emph_setting}, 6'h2b);
    @(posedge core_clk);
    host.read_pair(REG_TX_EQ, d, ok);
    chk(d, 16'h0503);
    @(posedge core_clk);
    host.write_pair(REG_TX_EQ, 16'h0707, ok);
    settle(2);
    chk({tx_eq_setting, rx_emph_setting}, 6'h3f);
  endtask : t_eq_emph

  task automatic t_wrap();
    logic       ok;
    logic [7:0] w;
    for (int i = 0; i < 5; i++) begin
      w = (i < 4) ? WRAP_SET[i] : 8'h00;
      @(posedge core_clk);
      host.write_pair(REG_WRAP, {w, 8'h05}, ok);
      settle(2);
      chk({laser_src_wrap, rx_cdr_engaged}, {2{w[WRAP_OPT_BIT]}});
      chk({rd_src_wrap, tx_cdr_engaged}, {2{w[WRAP_ELEC_BIT]}});
      chk(laser_enable, !w[WRAP_ELEC_BIT] || w[WRAP_PASS_BIT]);
      chk(rd_output_enable, !w[WRAP_OPT_BIT] || w[WRAP_PASS_BIT]);
    end
  endtask : t_wrap

  task automatic t_addr();
    logic ack;
    @(posedge core_clk);
    host.probe(DEV_ADDR_DEF + 7'h01, ack);
    chk(ack, 1'b0);
    @(posedge core_clk);
    host.probe(DEV_ADDR_DEF, ack);
    chk(ack, 1'b1);
  endtask : t_addr

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict

  initial begin
    #400_000;
    n_errors++;
    print_verdict();
  end

  initial begin
    rst_b          = 1'b0;
    rx_rate_select = 1'b0;
    tx_rate_select = 1'b0;
    tx_disable     = 1'b1;
    rx_coding_16g  = 1'b0;
    tx_coding_16g  = 1'b0;
    laser_fault    = 1'b0;
    rx_power_low   = 1'b0;
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge core_clk);
    t_reset();
    t_lock(1'b0);
    t_lock(1'b1);
    drv(1'b0, 1'b0, 1'b0);
    drv(1'b1, 1'b0, 1'b0);
    t_pins();
    t_eq_emph();
    t_wrap();
    t_addr();
    print_verdict();
  end
endmodule : testbench
